/* File: verilog/ubeq_defs.svh */
// Purpose: offsets, field positions, codes and reset values of the event qualifier
// Assumes: included by bare name from the design files
// Notes: definitions only
`ifndef UBEQ_DEFS_SVH
`define UBEQ_DEFS_SVH

`define UBEQ_ADDR_W 12
// register byte offsets
`define UBEQ_OFF_SEL_A 12'h000
`define UBEQ_OFF_ROUTE 12'h010
`define UBEQ_OFF_TALLY 12'h020
`define UBEQ_REG_RESET 32'h0000_0000

// event selection control fields
`define UBEQ_SEQ_CODE_HI 31
`define UBEQ_BR_CODE_HI 30
`define UBEQ_CODE_LO 25
`define UBEQ_MASK_HI 24
`define UBEQ_MASK_LO 9

// event codes and routing select codes
`define UBEQ_CODE_SWITCH 7'h05
`define UBEQ_CODE_QWRITE 7'h09
`define UBEQ_CODE_MISPRED 6'h05
`define UBEQ_CODE_BRANCH 6'h04
`define UBEQ_ROUTE_SEQ 3'h0
`define UBEQ_ROUTE_BR 3'h2

// counter routing config fields
`define UBEQ_ROUTE_SEL_HI 15
`define UBEQ_ROUTE_SEL_LO 13
`define UBEQ_ROUTE_EN 12

`endif

/* File: verilog/ubeq_pkg.sv */
// Purpose: carrier types of the event qualifier
// Assumes: nothing
// Notes: kind bits are cond, indirect call, return, indirect jump
package ubeq_pkg;
  // one micro-op queue write; src is build, delivery, rom
  typedef struct packed {
    logic valid;
    logic [2:0] src;
  } ubeq_uop_wr_t;

  // one retiring branch
  typedef struct packed {
    logic valid;
    logic mispred;
    logic [3:0] kind;
  } ubeq_branch_t;
endpackage

/* File: verilog/ubeq_qualify.sv */
// Purpose: decodes one pair of event selection words into hit terms
// Assumes: events are single-cycle qualifiers sampled on pclk
// Notes: purely combinational; the caller registers the result
`include "ubeq_defs.svh"

module ubeq_qualify (
  input wire logic [31:0] seq_sel,
  input wire logic [31:0] br_sel,
  input wire logic switch_evt,
  input wire ubeq_pkg::ubeq_uop_wr_t uop_wr,
  input wire ubeq_pkg::ubeq_branch_t branch,
  output logic seq_hit,
  output logic br_hit
);
  // field extraction
  wire [6:0] seq_code = seq_sel[`UBEQ_SEQ_CODE_HI:`UBEQ_CODE_LO];
  wire [15:0] seq_mask = seq_sel[`UBEQ_MASK_HI:`UBEQ_MASK_LO];
  wire [5:0] br_code = br_sel[`UBEQ_BR_CODE_HI:`UBEQ_CODE_LO];
  wire [15:0] br_mask = br_sel[`UBEQ_MASK_HI:`UBEQ_MASK_LO];

  // sequencer group: transfer needs cache_to_sequencer_mask (bit 0)
  wire cache_to_sequencer_mask = seq_mask[0];
  wire switch_hit = (seq_code == `UBEQ_CODE_SWITCH) & cache_to_sequencer_mask
                    & switch_evt;
  // any set source bit counts a matching write
  wire src_trace_building = seq_mask[0] & uop_wr.src[0];
  wire src_trace_delivery = seq_mask[1] & uop_wr.src[1];
  wire src_rom = seq_mask[2] & uop_wr.src[2];
  wire qwrite_hit = (seq_code == `UBEQ_CODE_QWRITE) & uop_wr.valid
                    & (src_trace_building | src_trace_delivery | src_rom);
  assign seq_hit = switch_hit | qwrite_hit;

  // branch class match; bit 4 covers every indirect kind
  wire class_hit = (br_mask[1] & branch.kind[0])
                 | (br_mask[2] & branch.kind[1])
                 | (br_mask[3] & branch.kind[2])
                 | (br_mask[4] & (branch.kind[1] | branch.kind[2] | branch.kind[3]));
  // mispredicts are counted as reported, overcount included
  wire mispred_hit = (br_code == `UBEQ_CODE_MISPRED) & branch.mispred;
  wire all_hit = (br_code == `UBEQ_CODE_BRANCH);
  assign br_hit = branch.valid & class_hit & (mispred_hit | all_hit);
endmodule

/* File: verilog/ubeq_top.sv */
// Purpose: apb-programmed qualifier turning core events into counter pulses
// Assumes: event inputs synchronous to pclk; one access phase wait state
// Notes: lanes 0..3 drive counters 4..7; lanes 0,1 use side a, 2,3 side b
//
// Implementation choices: the placing of the registers and register access over APB.
`include "ubeq_defs.svh"

module ubeq_top #(
  parameter int NUM_CNT = 4,
  parameter int TALLY_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`UBEQ_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sequencer_active,
  input wire ubeq_pkg::ubeq_uop_wr_t uop_wr,
  input wire ubeq_pkg::ubeq_branch_t branch,
  output logic [NUM_CNT-1:0] cnt_pulse
);
  // lane wiring and tally packing are fixed to four lanes in one word;
  // refused at elaboration so a bad build never reaches simulation
  if (NUM_CNT != 4) begin : g_bad_cnt
    $error("ubeq_top: NUM_CNT must be 4");
  end
  if (TALLY_W < 1 || TALLY_W > 8) begin : g_bad_tally
    $error("ubeq_top: TALLY_W must be 1..8");
  end

  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic seq_active_q;
  logic [NUM_CNT-1:0] pulse_q;
  logic [NUM_CNT-1:0] pulse_d;
  logic [31:0] sel_q [4];
  logic [31:0] route_q [NUM_CNT];
  logic [TALLY_W-1:0] tally_q [NUM_CNT];
  logic [31:0] rd_data;
  logic [1:0] seq_hit;
  logic [1:0] br_hit;

  // apb handshake: answer comes one cycle into the access phase
  wire access = psel & penable;
  wire first = access & ~pready_q;
  wire done = access & pready_q;
  wire wr_en = done & pwrite;
  wire [31:0] wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  // address decode
  wire [NUM_CNT-1:0] sel_hit;
  wire [NUM_CNT-1:0] route_hit;
  wire tally_hit = (paddr == `UBEQ_OFF_TALLY);
  wire mapped = (|sel_hit) | (|route_hit) | tally_hit;

  // a trace-store to sequencer change is a rising sequencer level
  wire switch_evt = sequencer_active & ~seq_active_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= `UBEQ_REG_RESET;
    end else begin
      pready_q <= first;
      pslverr_q <= first & ~mapped;
      prdata_q <= first ? rd_data : prdata_q;
    end
  end

  // edge memory and registered pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_active_q <= 1'b0;
      pulse_q <= '0;
    end else begin
      seq_active_q <= sequencer_active;
      pulse_q <= pulse_d;
    end
  end

  // one qualifier per side of the selection register pairs
  genvar s;
  generate
    for (s = 0; s < 2; s++) begin : g_side
      ubeq_qualify u_qualify (
        .seq_sel(sel_q[s]),
        .br_sel(sel_q[s+2]),
        .switch_evt(switch_evt),
        .uop_wr(uop_wr),
        .branch(branch),
        .seq_hit(seq_hit[s]),
        .br_hit(br_hit[s])
      );
    end
  endgenerate

  // selection registers: 0,1 sequencer side a,b; 2,3 branch side a,b
  genvar r;
  generate
    for (r = 0; r < 4; r++) begin : g_sel
      assign sel_hit[r] = (paddr == `UBEQ_OFF_SEL_A + 12'(4 * r));
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sel_q[r] <= `UBEQ_REG_RESET;
        end else if (wr_en & sel_hit[r]) begin
          sel_q[r] <= (sel_q[r] & ~wmask) | (pwdata & wmask);
        end
      end
    end
  endgenerate

  // per counter lane: routing register, pulse decode, tally
  genvar i;
  generate
    for (i = 0; i < NUM_CNT; i++) begin : g_lane
      wire [2:0] route_sel = route_q[i][`UBEQ_ROUTE_SEL_HI:`UBEQ_ROUTE_SEL_LO];
      wire route_en = route_q[i][`UBEQ_ROUTE_EN];
      assign route_hit[i] = (paddr == `UBEQ_OFF_ROUTE + 12'(4 * i));
      // select code steers the lane to one group; others stay quiet
      assign pulse_d[i] = route_en
        & (((route_sel == `UBEQ_ROUTE_SEQ) & seq_hit[i/2])
        | ((route_sel == `UBEQ_ROUTE_BR) & br_hit[i/2]));
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          route_q[i] <= `UBEQ_REG_RESET;
        end else if (wr_en & route_hit[i]) begin
          route_q[i] <= (route_q[i] & ~wmask) | (pwdata & wmask);
        end
      end
      // tally wraps; software sees activity without the counter path
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          tally_q[i] <= '0;
        end else begin
          tally_q[i] <= tally_q[i] + TALLY_W'(pulse_q[i]);
        end
      end
    end
  endgenerate

  // read mux; tally register is read-only, writes to it are dropped
  always_comb begin
    rd_data = 32'h0000_0000;
    for (int k = 0; k < 4; k++) begin
      if (sel_hit[k]) rd_data = rd_data | sel_q[k];
    end
    for (int k = 0; k < NUM_CNT; k++) begin
      if (route_hit[k]) rd_data = rd_data | route_q[k];
      if (tally_hit) rd_data[8*k +: TALLY_W] = tally_q[k];
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign cnt_pulse = pulse_q;

  // checks on lane 0 (counter 4, side a)
  wire [2:0] l0_sel = route_q[0][`UBEQ_ROUTE_SEL_HI:`UBEQ_ROUTE_SEL_LO];
  wire l0_en = route_q[0][`UBEQ_ROUTE_EN];
  wire [6:0] sa_code = sel_q[0][`UBEQ_SEQ_CODE_HI:`UBEQ_CODE_LO];
  wire [15:0] sa_mask = sel_q[0][`UBEQ_MASK_HI:`UBEQ_MASK_LO];
  wire [5:0] ba_code = sel_q[2][`UBEQ_BR_CODE_HI:`UBEQ_CODE_LO];
  wire [15:0] ba_mask = sel_q[2][`UBEQ_MASK_HI:`UBEQ_MASK_LO];
  wire l0_seq = l0_en & (l0_sel == `UBEQ_ROUTE_SEQ);
  wire l0_br = l0_en & (l0_sel == `UBEQ_ROUTE_BR);
  wire q_code = sa_code == `UBEQ_CODE_QWRITE;

  // lane 1 shares side a; lane 2 reads side b of the sequencer pair
  wire l1_br = route_q[1][`UBEQ_ROUTE_EN]
               & (route_q[1][`UBEQ_ROUTE_SEL_HI:`UBEQ_ROUTE_SEL_LO] == `UBEQ_ROUTE_BR);
  wire l2_seq = route_q[2][`UBEQ_ROUTE_EN]
                & (route_q[2][`UBEQ_ROUTE_SEL_HI:`UBEQ_ROUTE_SEL_LO] == `UBEQ_ROUTE_SEQ);
  wire [6:0] sb_code = sel_q[1][`UBEQ_SEQ_CODE_HI:`UBEQ_CODE_LO];
  wire [15:0] sb_mask = sel_q[1][`UBEQ_MASK_HI:`UBEQ_MASK_LO];

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_switch_pulse: assert property (
    (l0_seq && sa_code == `UBEQ_CODE_SWITCH && sa_mask[0] && sequencer_active
      && !$past(sequencer_active)) |=> cnt_pulse[0])
    else $error("switch did not pulse counter 4");
  a_switch_once: assert property (
    (l0_seq && sa_code == `UBEQ_CODE_SWITCH && sequencer_active[*2]) |=> !cnt_pulse[0])
    else $error("steady sequencer level pulsed");
  a_qwrite_any: assert property (
    (l0_seq && q_code && sa_mask[2:0] == 3'h7 && uop_wr.valid && uop_wr.src != 3'h0)
      |=> cnt_pulse[0])
    else $error("valid queue write not counted");
  a_qwrite_miss: assert property (
    (l0_seq && q_code && (sa_mask[2:0] & uop_wr.src) == 3'h0) |=> !cnt_pulse[0])
    else $error("unmatched queue write counted");
  a_build_src: assert property (
    (l0_seq && q_code && sa_mask[2:0] == 3'h1 && uop_wr.valid && uop_wr.src == 3'h1)
      |=> cnt_pulse[0])
    else $error("building source not counted");
  a_deliver_src: assert property (
    (l0_seq && q_code && sa_mask[2:0] == 3'h2 && uop_wr.valid && uop_wr.src == 3'h2)
      |=> cnt_pulse[0])
    else $error("delivery source not counted");
  a_rom_src: assert property (
    (l0_seq && q_code && sa_mask[2:0] == 3'h4 && uop_wr.valid && uop_wr.src == 3'h4)
      |=> cnt_pulse[0])
    else $error("rom source not counted");
  a_mispred_only: assert property (
    (l0_br && ba_code == `UBEQ_CODE_MISPRED && !branch.mispred) |=> !cnt_pulse[0])
    else $error("predicted branch counted as mispredict");
  a_indirect_class: assert property (
    (l0_br && ba_code == `UBEQ_CODE_MISPRED && ba_mask[4:1] == 4'h8 && branch.valid
      && branch.mispred && branch.kind == 4'h8) |=> cnt_pulse[0])
    else $error("indirect jump class missed");
  a_all_branch: assert property (
    (l0_br && ba_code == `UBEQ_CODE_BRANCH && ba_mask[1] && branch.valid
      && branch.kind[0]) |=> cnt_pulse[0])
    else $error("retiring conditional branch not counted");
  a_route_gate: assert property (
    (!l0_en || (l0_sel != `UBEQ_ROUTE_SEQ && l0_sel != `UBEQ_ROUTE_BR)) |=> !cnt_pulse[0])
    else $error("unrouted lane pulsed");
  a_code_gate: assert property (
    (l0_seq && sa_code != `UBEQ_CODE_SWITCH && !q_code) |=> !cnt_pulse[0])
    else $error("unknown event code pulsed");
  a_apb_answer: assert property (
    (psel && penable && !pready) |=> (pready && $stable(paddr)) or !psel)
    else $error("apb answer late");

  // bus answer shape: one-cycle ready, error only beside it
  a_ready_single: assert property (
    pready |=> !pready)
    else $error("pready held too long");
  a_err_with_ready: assert property (
    pslverr |-> pready)
    else $error("pslverr without pready");
  a_setup_quiet: assert property (
    (psel && !penable) |=> !pready)
    else $error("pready during setup");
  a_unmapped_err: assert property (
    (psel && penable && !pready && !mapped) |=> pslverr)
    else $error("unmapped access not flagged");

  // tally follows the registered pulse exactly, wrapping
  a_tally_step: assert property (
    1'b1 |=> (tally_q[0] == $past(tally_q[0]) + TALLY_W'($past(pulse_q[0]))))
    else $error("tally lane 0 skipped a pulse");

  // qualifier gates, and the side b and lane 1 paths, that the positive checks above do not reach
  a_switch_mask: assert property (
    (l0_seq && sa_code == `UBEQ_CODE_SWITCH && !sa_mask[0]) |=> !cnt_pulse[0])
    else $error("switch counted without mask bit");
  a_qwrite_invalid: assert property (
    (l0_seq && q_code && !uop_wr.valid) |=> !cnt_pulse[0])
    else $error("invalid queue write counted");
  a_qwrite_side_b: assert property (
    (l2_seq && sb_code == `UBEQ_CODE_QWRITE && uop_wr.valid
      && (sb_mask[2:0] & uop_wr.src) != 3'h0) |=> cnt_pulse[2])
    else $error("side b queue write not counted");
  a_cond_class: assert property (
    (l0_br && ba_code == `UBEQ_CODE_BRANCH && ba_mask[4:1] == 4'h1 && !branch.kind[0])
      |=> !cnt_pulse[0])
    else $error("non-conditional branch in conditional class");
  a_branch_invalid: assert property (
    (l0_br && !branch.valid) |=> !cnt_pulse[0])
    else $error("invalid branch counted");
  a_lane1_mispred: assert property (
    (l1_br && ba_code == `UBEQ_CODE_MISPRED && ba_mask[1] && branch.valid
      && branch.mispred && branch.kind[0]) |=> cnt_pulse[1])
    else $error("mispredicted conditional missed on counter 5");
endmodule

/* File: tb/ubeq_tb.sv */
// Purpose: self-checking bench for the event qualifier, programmed over apb
// Assumes: event inputs sampled at pclk, pulse registered one edge later
// Notes: every input changes by non-blocking assignment at the rising edge
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sequencer_active = 1'b0;
  ubeq_pkg::ubeq_uop_wr_t uop_wr = '0;
  ubeq_pkg::ubeq_branch_t branch = '0;
  logic [3:0] cnt_pulse;
  int mismatches = 0;
  int checks_done = 0;
  logic [31:0] rd;
  logic err;
  logic [3:0] want;

  // 200 MHz core clock
  always #2.5 pclk = ~pclk;

  ubeq_top #(.NUM_CNT(4), .TALLY_W(8)) i_ubeq_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sequencer_active(sequencer_active), .uop_wr(uop_wr), .branch(branch),
    .cnt_pulse(cnt_pulse)
  );

  // verdict and end of run, also reached by a timeout
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t %s seen %h want %h", $time, what, seen, exp);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
      if (n > 16) begin
        mismatches++;
        complete_run();
      end
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one event cycle, then the pulse is looked at in the following cycle
  task automatic ev(input logic sa, input ubeq_pkg::ubeq_uop_wr_t u,
                    input ubeq_pkg::ubeq_branch_t b, input logic [3:0] exp);
    @(posedge pclk);
    sequencer_active <= sa;
    uop_wr <= u;
    branch <= b;
    @(posedge pclk);
    sequencer_active <= 1'b0;
    uop_wr <= '0;
    branch <= '0;
    #1;
    chk({28'h0, cnt_pulse}, {28'h0, exp}, "pulse");
  endtask

  function automatic logic [31:0] seq_w(input logic [6:0] c, input logic [15:0] m);
    return {c, m, 9'h0};
  endfunction

  function automatic logic [31:0] br_w(input logic [5:0] c, input logic [15:0] m);
    return {1'b0, c, m, 9'h0};
  endfunction

  // routing word: select in 15:13, enable in 12
  function automatic logic [31:0] route(input logic [2:0] s);
    return {16'h0, s, 1'b1, 12'h000};
  endfunction

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // register defaults, readback, unmapped access
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0, "sel reset");
    apb(1'b0, 12'h020, 32'h0);
    chk(rd, 32'h0, "tally reset");
    apb(1'b1, 12'h010, route(3'h0));
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, route(3'h0), "route readback");
    apb(1'b0, 12'h030, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    $display("test registers done");
    // delivery switch on lane 0
    apb(1'b1, 12'h000, seq_w(7'h05, 16'h0001));
    ev(1'b1, '0, '0, 4'b0001);
    ev(1'b0, '0, '0, 4'b0000);
    apb(1'b1, 12'h010, route(3'h1));
    ev(1'b1, '0, '0, 4'b0000);
    apb(1'b1, 12'h010, route(3'h0));
    apb(1'b1, 12'h000, seq_w(7'h05, 16'h0000));
    ev(1'b1, '0, '0, 4'b0000);
    apb(1'b1, 12'h000, seq_w(7'h06, 16'h0001));
    ev(1'b1, '0, '0, 4'b0000);
    $display("test switch done");
    // queue writes on lanes 0 and 2 (both sides), every nonzero mask against every source
    apb(1'b1, 12'h018, route(3'h0));
    for (int m = 1; m < 8; m++) begin
      apb(1'b1, 12'h000, seq_w(7'h09, {13'h0, m[2:0]}));
      apb(1'b1, 12'h004, seq_w(7'h09, {13'h0, m[2:0]}));
      for (int s = 0; s < 8; s++) begin
        want = {1'b0, |(m[2:0] & s[2:0]), 1'b0, |(m[2:0] & s[2:0])};
        ev(1'b0, '{1'b1, s[2:0]}, '0, want);
      end
      ev(1'b0, '{1'b0, 3'h7}, '0, 4'b0000);
    end
    apb(1'b1, 12'h018, 32'h0);
    $display("test queue done");
    // branch classes on lanes 0 and 1, mispredicted and all retiring
    apb(1'b1, 12'h010, route(3'h2));
    apb(1'b1, 12'h014, route(3'h2));
    for (int c = 4; c < 6; c++) begin
      for (int mb = 1; mb < 5; mb++) begin
        apb(1'b1, 12'h008, br_w(c[5:0], 16'h0001 << mb));
        for (int k = 0; k < 16; k++) begin
          for (int mp = 0; mp < 2; mp++) begin
            want = 4'b0000;
            if ((c == 4 || mp == 1) && (mb == 4 ? |k[3:1] : k[mb-1])) begin
              want = 4'b0011;
            end
            ev(1'b0, '0, '{1'b1, mp[0], k[3:0]}, want);
          end
        end
      end
    end
    apb(1'b1, 12'h010, route(3'h0));
    apb(1'b1, 12'h014, route(3'h0));
    ev(1'b0, '0, '{1'b1, 1'b1, 4'h1}, 4'b0000);
    $display("test branch done");
    complete_run();
  end
endmodule
